// ### rtl/mbp_port.sv
/*
 multiplexed byte-wide host bus port with a small byte store behind it.
 assumes the host pins are asynchronous to clk and that a pad ring
 resolves the shared lines from muxed_addr_data_bus_out and muxed_addr_data_bus_oe.
 every pin passes two flops and an edge stage, so the port sees a pin
 change on the third clock edge after it; the host must hold each
 strobe level for at least two clocks and keep the address on the
 shared lines for three clocks after the latch strobe falls.
 the strap is followed continuously; it is meant to be tied, and a
 change while a cycle is open gives undefined results.
 the store has no reset, so a read before any write returns unknown.
 no bus clock reaches the port: all timing is rebuilt from the strobes.
*/
// Summary of operation
// - strap high strobe style, low enable style
// - address latched on latch strobe falling edge
// - write on strobe fall or rw rise
// - drive read data during later strobe part
// - release bus on read strobe end edge
// - unselected cycle latches address, no access
// - latch strobe rising edge clears address
`timescale 1ns/1ps
module mbp_port
	import mbp_pkg::*;
#(
	parameter int DATA_W = MBP_DATA_W,
	parameter int LOC_N = MBP_LOC_N
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_style_select,
	input wire logic unit_select_n,
	input wire logic addr_latch_strobe,
	input wire logic data_read_strobe,
	input wire logic read_write,
	input wire logic [DATA_W-1:0] muxed_addr_data_bus_in,
	output logic [DATA_W-1:0] muxed_addr_data_bus_out,
	output logic muxed_addr_data_bus_oe,
	output logic [MBP_ADDR_W-1:0] latched_addr,
	output logic addr_valid
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one is read only by stage two
	mbp_pins_t pins_raw;
	mbp_pins_t sync1_reg, sync1_next;
	mbp_pins_t sync2_reg, sync2_next;
	mbp_pins_t prev_reg, prev_next;
	mbp_edges_t edg;

	assign pins_raw = '{style_strobe: bus_style_select, cs_n: unit_select_n,
		als: addr_latch_strobe, drs: data_read_strobe, rw: read_write,
		ad: muxed_addr_data_bus_in};

	always_comb begin
		sync1_next = pins_raw;
		sync2_next = sync1_reg;
		prev_next = sync2_reg;
	end

	// idle levels: strobes low, rw high, deselected; keeps false edges off
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_reg <= MBP_PINS_IDLE;
			sync2_reg <= MBP_PINS_IDLE;
			prev_reg <= MBP_PINS_IDLE;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg <= prev_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// strap followed every clock after reset release; reset loads low
	logic style_reg, style_next;

	always_comb begin
		style_next = style_reg;
		if (reset)
			style_next = 1'b0;
		else
			style_next = sync2_reg.style_strobe;
	end

	always_ff @(posedge clk) begin
		style_reg <= style_next;
	end

	////////////////////////////////////////////////////////////////////
	// helpers shared by the edge and window decoders
	function automatic logic level_rose(input logic was, input logic now);
		return ~was & now;
	endfunction

	function automatic logic level_fell(input logic was, input logic now);
		return was & ~now;
	endfunction

	// read window level for one pin sample in the given bus style
	function automatic logic read_level(input logic strobe_style, input mbp_pins_t p);
		if (strobe_style)
			return p.drs & p.rw;
		else
			return ~p.drs & p.rw;
	endfunction

	////////////////////////////////////////////////////////////////////
	// edge detection on synchronised strobes
	always_comb begin
		edg.als_fall = level_fell(prev_reg.als, sync2_reg.als);
		edg.als_rise = level_rose(prev_reg.als, sync2_reg.als);
		// strobe style: drs trailing edge; enable style: rw rising
		if (style_reg) begin
			edg.wr_take = level_fell(prev_reg.drs, sync2_reg.drs) & ~prev_reg.rw;
			edg.rd_end = level_fell(prev_reg.drs, sync2_reg.drs);
		end else begin
			edg.wr_take = level_rose(prev_reg.rw, sync2_reg.rw);
			edg.rd_end = level_rose(prev_reg.drs, sync2_reg.drs);
		end
	end

	////////////////////////////////////////////////////////////////////
	// address latch
	logic [MBP_ADDR_W-1:0] addr_reg, addr_next;
	logic valid_reg, valid_next;

	always_comb begin
		addr_next = addr_reg;
		valid_next = valid_reg;
		if (edg.als_rise) begin
			addr_next = MBP_ADDR_CLEAR;
			valid_next = 1'b0;
		end else if (edg.als_fall) begin
			// deselected cycles still latch the address
			addr_next = sync2_reg.ad[MBP_ADDR_W-1:0];
			valid_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			addr_reg <= MBP_ADDR_CLEAR;
			valid_reg <= 1'b0;
		end else begin
			addr_reg <= addr_next;
			valid_reg <= valid_next;
		end
	end

	assign latched_addr = addr_reg;
	assign addr_valid = valid_reg;

	////////////////////////////////////////////////////////////////////
	// byte store
	logic [DATA_W-1:0] mem [LOC_N];
	logic wr_en;
	logic [MBP_ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;

	// data is the sample beside the old level, one before the take edge
	always_comb begin
		wr_en = edg.wr_take & ~prev_reg.cs_n & valid_reg;
		wr_addr = addr_reg;
		wr_data = prev_reg.ad;
	end

	// store has no reset: contents survive like backed ram
	always_ff @(posedge clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	////////////////////////////////////////////////////////////////////
	// read window and output enable
	logic rd_level_now;
	logic rd_access;
	logic rd_window;
	logic oe_reg, oe_next;

	always_comb begin
		rd_level_now = read_level(style_reg, sync2_reg);
		// access needs select held across the strobe; als high closes it
		rd_access = ~sync2_reg.cs_n & valid_reg & ~sync2_reg.als;
		rd_window = rd_level_now & rd_access;
		oe_next = rd_window & ~edg.rd_end;
	end

	always_ff @(posedge clk) begin
		if (reset)
			oe_reg <= 1'b0;
		else
			oe_reg <= oe_next;
	end

	////////////////////////////////////////////////////////////////////
	// read data: loaded while the window is open, held after it closes
	logic [DATA_W-1:0] dout_reg, dout_next;

	always_comb begin
		dout_next = dout_reg;
		if (rd_window)
			dout_next = mem[addr_reg];
	end

	always_ff @(posedge clk) begin
		if (reset)
			dout_reg <= MBP_MEM_RESET;
		else
			dout_reg <= dout_next;
	end

	assign muxed_addr_data_bus_out = dout_reg;
	assign muxed_addr_data_bus_oe = oe_reg;
endmodule

// ### rtl/mbp_pkg.sv
/*
 muxed byte bus host port: shared constants and carrier types.
 assumes a single 40 MHz clock domain in the enclosing device.
*/
package mbp_pkg;
	localparam int MBP_DATA_W = 8;
	localparam int MBP_LOC_N = 128;
	localparam int MBP_ADDR_W = 7;
	localparam logic [MBP_DATA_W-1:0] MBP_MEM_RESET = 8'h00;
	localparam logic [MBP_ADDR_W-1:0] MBP_ADDR_CLEAR = 7'h00;
	localparam int MBP_CLK_PERIOD_NS = 25;
	localparam int MBP_SYNC_STAGES = 2;

	// synchronised host pins, sampled once per clock
	typedef struct packed {
		logic style_strobe;
		logic cs_n;
		logic als;
		logic drs;
		logic rw;
		logic [MBP_DATA_W-1:0] ad;
	} mbp_pins_t;

	// pin levels of an idle, deselected bus; preloads the synchronisers
	localparam mbp_pins_t MBP_PINS_IDLE = '{style_strobe: 1'b0, cs_n: 1'b1, als: 1'b0,
		drs: 1'b0, rw: 1'b1, ad: 8'h00};

	// per-clock strobe edges derived from the pins
	typedef struct packed {
		logic als_fall;
		logic als_rise;
		logic wr_take;
		logic rd_end;
	} mbp_edges_t;
endpackage

// ### verif/mbp_port_assertions.sv
/* pin-level checker for the host port; assumes it is bound into mbp_port */
`timescale 1ns/1ps
module mbp_port_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_style_select,
	input wire logic unit_select_n,
	input wire logic addr_latch_strobe,
	input wire logic data_read_strobe,
	input wire logic read_write,
	input wire logic [7:0] muxed_addr_data_bus_in,
	input wire logic [7:0] muxed_addr_data_bus_out,
	input wire logic muxed_addr_data_bus_oe,
	input wire logic [6:0] latched_addr,
	input wire logic addr_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire oe = muxed_addr_data_bus_oe;
	wire rd_lvl = bus_style_select ? data_read_strobe : !data_read_strobe;
	// six samples cover the three stage pin path plus slack
	wire win = rd_lvl && read_write && !unit_select_n && !addr_latch_strobe && addr_valid;
	chk_rd_drive: assert property (win[*6] |-> oe) else $error("no drive");
	chk_rd_end: assert property ((!win)[*6] |-> !oe) else $error("late release");
	chk_unsel_quiet: assert property (unit_select_n[*6] |-> !oe) else $error("unsel");
	chk_style_idle: assert property ((!rd_lvl)[*6] |-> !oe) else $error("style");
	chk_wr_quiet: assert property ((!read_write)[*6] |-> !oe) else $error("wr drive");
	chk_addr_take: assert property ($fell(addr_latch_strobe) |-> ##5 addr_valid
		&& latched_addr == $past(muxed_addr_data_bus_in[6:0], 5)) else $error("latch");
	chk_addr_clear: assert property ($rose(addr_latch_strobe) |-> ##5 !addr_valid
		&& latched_addr == 7'h00) else $error("clear");
	chk_data_hold: assert property (oe && $past(oe) |-> $stable(muxed_addr_data_bus_out))
		else $error("data moved");
endmodule
bind mbp_port mbp_port_assertions mbp_port_assertions_inst (.*);

// ### verif/mbp_host.sv
/* host model of the shared byte bus; assumes the bench calls its tasks */
`timescale 1ns/1ps
module mbp_host (
	input wire logic clk,
	input wire logic sty,
	input wire logic [7:0] dout,
	input wire logic oe,
	output logic cs_n = 1'b1,
	output logic als = 1'b0,
	output logic drs = 1'b0,
	output logic rw = 1'b1,
	output logic [7:0] bus
);
	logic [7:0] ad = 8'h00;
	logic hdrv = 1'b0;
	// released lines show the inverse of the last host byte
	assign bus = oe ? dout : (hdrv ? ad : ~ad);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic latch(input logic [7:0] a);
		cyc(1);
		{hdrv, ad, als, drs} = {1'b1, a, 1'b1, !sty};
		cyc(6);
		als = 1'b0;
		cyc(6);
	endtask
	task automatic wr(input logic [7:0] a, d, input logic sel);
		latch(a);
		{cs_n, rw, ad, drs} = {!sel, 1'b0, d, 1'b1};
		cyc(4);
		if (sty) drs = 1'b0;
		else rw = 1'b1;
		cyc(4);
		{cs_n, rw, drs, hdrv} = {1'b1, 1'b1, !sty, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, input logic sel, output logic [7:0] d, output logic en);
		latch(a);
		{hdrv, cs_n, rw, drs} = {1'b0, !sel, 1'b1, sty};
		cyc(6);
		{d, en} = {bus, oe};
		drs = !sty;
		cyc(6);
		cs_n = 1'b1;
	endtask
endmodule

// ### verif/muxed_byte_bus_host_port_test.sv
/* self-checking bench for mbp_port; assumes mbp_host as the bus master */
`timescale 1ns/1ps
module muxed_byte_bus_host_port_test;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic sty = 1'b1;
	logic cs_n, als, drs, rw, oe, vld, en;
	logic [7:0] bus, dout, d;
	logic [6:0] la;
	int bad_count = 0;
	int n_checks = 0;
	always #12.5 clk = ~clk;
	mbp_port mbp_port_inst (.clk(clk), .reset(reset), .bus_style_select(sty),
		.unit_select_n(cs_n), .addr_latch_strobe(als), .data_read_strobe(drs),
		.read_write(rw), .muxed_addr_data_bus_in(bus), .muxed_addr_data_bus_out(dout),
		.muxed_addr_data_bus_oe(oe), .latched_addr(la), .addr_valid(vld));
	mbp_host mbp_host_inst (.*);
	task automatic chk(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// back-to-back writes at both address ends and one mid address, then read back
	task automatic t_rw;
		logic [7:0] at [3] = '{8'h00, 8'h7f, 8'h41};
		foreach (at[i]) mbp_host_inst.wr(at[i], at[i] ^ {sty, 7'h35}, 1'b1);
		foreach (at[i]) begin
			mbp_host_inst.rd(at[i], 1'b1, d, en);
			chk(d, at[i] ^ {sty, 7'h35});
			chk(en, 1'b1);
			chk(la, at[i]);
			chk(vld, 1'b1);
			chk(oe, 1'b0);
		end
	endtask
	// unselected cycles latch but neither store nor drive; bit 7 is ignored
	task automatic t_unsel;
		mbp_host_inst.wr(8'h85, 8'hc3, 1'b1);
		mbp_host_inst.wr(8'h05, 8'h3c, 1'b0);
		mbp_host_inst.rd(8'h05, 1'b0, d, en);
		chk(en, 1'b0);
		chk(la, 8'h05);
		chk(vld, 1'b1);
		mbp_host_inst.rd(8'h05, 1'b1, d, en);
		chk(d, 8'hc3);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 reset = 1'b0;
		repeat (2) begin
			t_rw();
			t_unsel();
			sty = 1'b0;
		end
		results();
	end
	initial begin
		#100us;
		bad_count++;
		results();
	end
endmodule
